//--- ext_res_bank.sv
// Purpose: extended-resolution low bits, third configuration register
// Assumes: conversion results arrive synchronous to aclk with a valid pulse
// Notes: shared pin is open drain; oe high while the pin is pulled low
//
// Notes on behaviour
// - bits 1:0 of the low-bits register show the two lsbs of the 12 v result, read only.
// - bits 3:2 show the two lsbs of the first remote temperature result, read only.
// - bits 5:4 show the two lsbs of the on-chip temperature result, read only.
// - bits 7:6 show the two lsbs of the second remote temperature result, read only.
// - reading the low-bits register freezes it and the high-byte registers until those are read.
// - the low-bits register reads zero after reset.
// - the third configuration register reads zero after reset.
// - configuration bit 0 turns the shared pin into the alert output for out-of-limit events while bit 1 is zero.
// - with the thermal pin enabled, an asserted pin while fans run and full_speed_on_thermal is set drives full speed.
// - the thermal pin can start a timer when it becomes asserted.
// - while configuration bit 1 is zero the pin measures 2.5 v and is not a thermal input.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ext_res_bank
  import ext_res_pkg::*;
#(
  parameter int addr_width = 12,
  parameter int timer_width = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // conversion side
  input wire conv_result_t conv_result,
  input wire logic conv_valid,
  input wire logic out_of_limit,
  input wire logic fans_running,
  // shared pin, open drain
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  // fan and measurement steering
  output logic fans_full_speed,
  output logic measure_2v5_enable,
  output logic frozen
);

  // result shadows seen by software
  logic [7:0] ext_lsb;
  logic [7:0] msb [4];
  logic [7:0] cfg3;
  logic timer_enable;
  logic [timer_width-1:0] thermal_alarm_pin_timer;
  logic thermal_alarm_pin_prev;

  // write channel state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_index;
  logic [7:0] w_byte;
  logic w_lane0;

  // read side decode
  logic [7:0] ar_index;
  logic rd_fire;
  logic wr_fire;
  logic lsb_read;
  logic [3:0] msb_read;
  logic timer_read;
  logic thermal_asserted;

  // word index from a byte address
  function automatic logic [7:0] word_index(input logic [addr_width-1:0] a);
    return 8'(a >> 2);
  endfunction

  // which index belongs to a high-byte channel
  function automatic logic [7:0] msb_index(input int ch);
    unique case (ch)
      ch_12v: return idx_msb_12v;
      ch_rem1: return idx_msb_rem1;
      ch_local: return idx_msb_local;
      default: return idx_msb_rem2;
    endcase
  endfunction

  // read decode for mapped registers
  function automatic logic mapped(input logic [7:0] i);
    return (i >= idx_ext_lsb) && (i <= idx_timer_ctrl);
  endfunction

  assign ar_index = word_index(s_axi_araddr);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign lsb_read = rd_fire && (ar_index == idx_ext_lsb);
  assign timer_read = rd_fire && (ar_index == idx_thermal_alarm_pin_timer);

  // per-channel high-byte read strobes
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      msb_read[c] = rd_fire && (ar_index == msb_index(c));
    end
  end

  // pin is a thermal input only when the thermal function is enabled
  assign thermal_asserted = cfg3[cfg_thermal_alarm_pin_en_bit] && !shared_pin_in;

  // freeze tracker; frozen equals any channel still pending, so the
  // per-channel mask is not needed here and stays inside the tracker
  read_freeze #(
    .channels(4)
  ) u_freeze (
    .aclk(aclk),
    .aresetn(aresetn),
    .lsb_read(lsb_read),
    .msb_read(msb_read),
    .frozen(frozen),
    .pending()
  );

  // low bits of every result; held while a read freeze is active
  // a result landing on the freezing read's own edge is dropped as well
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_lsb <= ext_lsb_reset;
    end else if (conv_valid && !frozen && !lsb_read) begin
      ext_lsb[1:0] <= conv_result.volt12[1:0];
      ext_lsb[3:2] <= conv_result.rem1[1:0];
      ext_lsb[5:4] <= conv_result.local_temp[1:0];
      ext_lsb[7:6] <= conv_result.rem2[1:0];
    end
  end

  // high bytes share the freeze with the low bits, so software always reads
  // one consistent set; a new result is dropped, not queued, while frozen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < 4; c++) begin
        msb[c] <= msb_reset;
      end
    end else if (conv_valid && !frozen && !lsb_read) begin
      msb[ch_12v] <= conv_result.volt12[9:2];
      msb[ch_rem1] <= conv_result.rem1[9:2];
      msb[ch_local] <= conv_result.local_temp[9:2];
      msb[ch_rem2] <= conv_result.rem2[9:2];
    end
  end

  // write address channel: hold one address until its response is raised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_index <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_index <= word_index(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // write data channel: only byte lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // ready flops drop as soon as a beat is taken, so no second beat slips in
  // a new write is only offered once the previous response has been taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
        && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready)
        && !s_axi_bvalid;
    end
  end

  // write response follows once both address and data are held
  // read-only targets refuse the write with slverr and keep their value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (!mapped(aw_index)) begin
        s_axi_bresp <= resp_decerr;
      end else if (aw_index == idx_cfg3 || aw_index == idx_timer_ctrl) begin
        s_axi_bresp <= resp_okay;
      end else begin
        s_axi_bresp <= resp_slverr; // read-only target
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration three; undefined upper bits stay zero
  // the mask keeps unimplemented bits at zero so a read-back never shows junk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg3 <= cfg3_reset;
    end else if (wr_fire && w_lane0 && aw_index == idx_cfg3) begin
      cfg3 <= w_byte & cfg3_wmask;
    end
  end

  // timer enable for the thermal pin, bit 0 of its control word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_enable <= 1'b0;
    end else if (wr_fire && w_lane0 && aw_index == idx_timer_ctrl) begin
      timer_enable <= w_byte[0];
    end
  end

  // read address: accept one address only when no answer is waiting
  // single outstanding read keeps the freeze bookkeeping to one strobe a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
    end
  end

  // read data one cycle after the address is taken
  // unmapped indexes answer with zero data and a decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(ar_index) ? resp_okay : resp_decerr;
      s_axi_rdata <= 32'h0000_0000;
      unique case (ar_index)
        idx_ext_lsb: s_axi_rdata[7:0] <= ext_lsb;
        idx_cfg3: s_axi_rdata[7:0] <= cfg3;
        idx_msb_12v: s_axi_rdata[7:0] <= msb[ch_12v];
        idx_msb_rem1: s_axi_rdata[7:0] <= msb[ch_rem1];
        idx_msb_local: s_axi_rdata[7:0] <= msb[ch_local];
        idx_msb_rem2: s_axi_rdata[7:0] <= msb[ch_rem2];
        idx_thermal_alarm_pin_timer: s_axi_rdata[timer_width-1:0] <= thermal_alarm_pin_timer;
        idx_timer_ctrl: s_axi_rdata[0] <= timer_enable;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // last level of the thermal input, for the assertion edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_alarm_pin_prev <= 1'b0;
    end else begin
      thermal_alarm_pin_prev <= thermal_asserted;
    end
  end

  // assertion time counter; restarts on each new assertion, saturates,
  // and clears on read unless the pin is still counting that cycle
  // limitation: a saturated count reads all ones until it is cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_alarm_pin_timer <= timer_reset[timer_width-1:0];
    end else if (timer_enable && thermal_asserted && !thermal_alarm_pin_prev) begin
      thermal_alarm_pin_timer <= timer_width'(1);
    end else if (timer_enable && thermal_asserted) begin
      if (thermal_alarm_pin_timer != '1) begin
        thermal_alarm_pin_timer <= thermal_alarm_pin_timer + timer_width'(1);
      end
    end else if (timer_read) begin
      thermal_alarm_pin_timer <= '0;
    end
  end

  // full_speed_on_thermal to full speed while the thermal input is held low
  // registered, so fans react one cycle after the pin; harmless at fan rates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fans_full_speed <= 1'b0;
    end else begin
      fans_full_speed <= thermal_asserted && fans_running
        && cfg3[cfg_full_speed_on_thermal_bit];
    end
  end

  // 2.5 v measurement owns the pin unless the thermal function is on
  // leaves reset enabled, matching a cleared thermal pin enable bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      measure_2v5_enable <= 1'b1;
    end else begin
      measure_2v5_enable <= !cfg3[cfg_thermal_alarm_pin_en_bit];
    end
  end

  // alert output is active low open drain; only pulled while routed there,
  // and never while the pin serves as the thermal input
  // the driven level is fixed low; oe alone decides whether the line is pulled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_pin_oe <= 1'b0;
      shared_pin_out <= 1'b0;
    end else begin
      shared_pin_out <= 1'b0;
      shared_pin_oe <= cfg3[cfg_alert_bit] && !cfg3[cfg_thermal_alarm_pin_en_bit]
        && out_of_limit;
    end
  end

endmodule

//--- ext_res_pkg.sv
// Purpose: shared constants and types for the extended-resolution bank
// Assumes: 32-bit axi4-lite data, one word per register
// Notes: register offsets are word indexes, byte address is four times
package ext_res_pkg;

  // register indexes (byte address = index * 4)
  localparam logic [7:0] idx_ext_lsb = 8'h77;
  localparam logic [7:0] idx_cfg3 = 8'h78;
  localparam logic [7:0] idx_msb_12v = 8'h79;
  localparam logic [7:0] idx_msb_rem1 = 8'h7a;
  localparam logic [7:0] idx_msb_local = 8'h7b;
  localparam logic [7:0] idx_msb_rem2 = 8'h7c;
  localparam logic [7:0] idx_thermal_alarm_pin_timer = 8'h7d;
  localparam logic [7:0] idx_timer_ctrl = 8'h7e;

  // configuration three fields
  localparam int cfg_alert_bit = 0;
  localparam int cfg_thermal_alarm_pin_en_bit = 1;
  localparam int cfg_full_speed_on_thermal_bit = 2;
  localparam logic [7:0] cfg3_wmask = 8'h07;

  // reset values
  localparam logic [7:0] ext_lsb_reset = 8'h00;
  localparam logic [7:0] cfg3_reset = 8'h00;
  localparam logic [7:0] msb_reset = 8'h00;
  localparam logic [15:0] timer_reset = 16'h0000;

  // axi response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam logic [1:0] resp_decerr = 2'h3;

  // channel order inside the low-bits register and freeze mask
  localparam int ch_12v = 0;
  localparam int ch_rem1 = 1;
  localparam int ch_local = 2;
  localparam int ch_rem2 = 3;

  // one set of 10-bit conversion results
  typedef struct packed {
    logic [9:0] rem2;
    logic [9:0] local_temp;
    logic [9:0] rem1;
    logic [9:0] volt12;
  } conv_result_t;

endpackage

//--- ext_res_props.sv
// Purpose: port-level checks for the extended-resolution bank
// Assumes: one clock, synchronous active-low reset
// Notes: registers are unseen here, so outputs are tied to their input causes
`timescale 1ns/100ps
module ext_res_props
  import ext_res_pkg::*;
#(
  parameter int addr_width = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic out_of_limit,
  input wire logic fans_running,
  input wire logic shared_pin_in,
  input wire logic shared_pin_oe,
  input wire logic fans_full_speed,
  input wire logic measure_2v5_enable,
  input wire logic frozen
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // read-address handshakes, and the one aimed at the low-bits register
  logic ar_fire;
  logic lsb_ar;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign lsb_ar = ar_fire && (s_axi_araddr[9:2] == idx_ext_lsb);

  a_freeze_start: assert property (lsb_ar |=> frozen)
    else $error("freeze not set after low-bits read");
  a_freeze_hold: assert property (frozen && !ar_fire |=> frozen)
    else $error("freeze dropped without a read");
  a_freeze_end: assert property ($fell(frozen) |-> $past(ar_fire))
    else $error("freeze released without a read");
  a_alert_cause: assert property (shared_pin_oe |-> $past(out_of_limit))
    else $error("alert driven without out-of-limit");
  a_alert_vs_pin: assert property (shared_pin_oe |-> measure_2v5_enable)
    else $error("alert driven while pin is thermal input");
  a_full_speed_on_thermal_cause: assert property (fans_full_speed |-> $past(fans_running) && !$past(shared_pin_in))
    else $error("full speed without running fans and asserted pin");
  a_full_speed_on_thermal_vs_pin: assert property (fans_full_speed |-> !measure_2v5_enable)
    else $error("full speed while pin measures voltage");
  a_rdata_steady: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before accepted");

  // main scenarios reached
  c_freeze: cover property (lsb_ar);
  c_release: cover property ($fell(frozen));
  c_alert: cover property (shared_pin_oe);
  c_full_speed_on_thermal: cover property (fans_full_speed);
  c_read_wait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind ext_res_bank ext_res_props #(.addr_width(addr_width)) u_props (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .out_of_limit, .fans_running,
  .shared_pin_in, .shared_pin_oe, .fans_full_speed, .measure_2v5_enable, .frozen);

//--- host_model.sv
// Purpose: register-bus controller standing in for host software
// Assumes: one transfer at a time, driven right after rising edges
// Notes: released address and data lines show the inverse, never stale values
`timescale 1ns/100ps
module host_model (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bit aw_done = 1'b0;
    bit w_done = 1'b0;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // gap edge so the next request never re-drives in this time step
    @(posedge aclk);
  endtask

  // one read; rready comes after a random pause so held read data is exercised,
  // then stays high until the answer is sampled
  task automatic rd(input logic [7:0] idx);
    int unsigned pause = $urandom % 3;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~s_axi_araddr;
    repeat (pause) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

//--- read_freeze.sv
// Purpose: tracks the freeze started by a read of the low-bits register
// Assumes: at most one register read per cycle
// Notes: freeze holds until every high-byte register has been read
`timescale 1ns/100ps
module read_freeze
  import ext_res_pkg::*;
#(
  parameter int channels = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lsb_read,
  input wire logic [channels-1:0] msb_read,
  output logic frozen,
  output logic [channels-1:0] pending
);

  // arm all channels on a low-bits read; each high-byte read clears one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= '0;
    end else if (lsb_read) begin
      pending <= '1;
    end else begin
      pending <= pending & ~msb_read;
    end
  end

  // freeze ends on the cycle the last pending channel is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frozen <= 1'b0;
    end else if (lsb_read) begin
      frozen <= 1'b1;
    end else if ((pending & ~msb_read) == '0) begin
      frozen <= 1'b0;
    end
  end

endmodule

//--- tb.sv
// Purpose: self-checking bench for the extended-resolution bank
// Assumes: 50 MHz clock, reset held five cycles
// Notes: expected bus answers are queued and checked as responses appear
`timescale 1ns/100ps
module tb
  import ext_res_pkg::*;
;
  logic aclk, aresetn, conv_valid, out_of_limit, fans_running, thermal_alarm_pin_drive;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic shared_pin_in, shared_pin_out, shared_pin_oe, fans_full_speed, measure_2v5_enable, frozen;
  conv_result_t conv_result, cv;
  int err_count, cmp_count;
  logic [34:0] rq[$], bq[$], e;

  // open-drain pin with pull-up: low when either side pulls
  assign shared_pin_in = !((shared_pin_oe && !shared_pin_out) || thermal_alarm_pin_drive);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  ext_res_bank uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_result, .conv_valid,
    .out_of_limit, .fans_running, .shared_pin_in, .shared_pin_out, .shared_pin_oe, .fans_full_speed,
    .measure_2v5_enable, .frozen);
  host_model hm (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // queue the expectation, then run the transfer
  task rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] rs, input bit dc = 1'b1);
    rq.push_back({dc, rs, exp});
    hm.rd(idx);
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] rs);
    bq.push_back({3'h0, rs, 30'h0});
    hm.wr(idx, d);
  endtask

  task conv(input conv_result_t c);
    conv_result <= c;
    conv_valid <= 1'b1;
    @(posedge aclk);
    conv_valid <= 1'b0;
  endtask

  // lsb read, a conversion that must be ignored, then the four high bytes
  task rd_set(input conv_result_t c);
    rd(idx_ext_lsb, {24'h0, c.rem2[1:0], c.local_temp[1:0], c.rem1[1:0], c.volt12[1:0]}, resp_okay);
    conv(~c);
    chk("frozen", {31'h0, frozen}, 32'h1);
    for (int i = 0; i < 4; i++) rd(idx_msb_12v + 8'(i), {24'h0, 8'(40'(c) >> (10 * i + 2))}, resp_okay);
    chk("frozen", {31'h0, frozen}, 32'h0);
  endtask

  // response watcher: oldest expectation against each answer
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      e = rq.pop_front();
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, e[33:32]});
      if (e[34]) chk("rdata", s_axi_rdata, e[31:0]);
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      e = bq.pop_front();
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, e[31:30]});
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict;
  end

  initial begin
    {aresetn, conv_valid, out_of_limit, fans_running, thermal_alarm_pin_drive} = '0;
    conv_result = '0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(44441));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_set('0);
    rd(idx_cfg3, 32'h0, resp_okay);
    repeat (4) begin
      cv = 40'({$urandom, $urandom});
      conv(cv);
      rd_set(cv);
      conv(~cv);
      rd(idx_msb_12v, {24'h0, 8'(~cv.volt12 >> 2)}, resp_okay);
    end
    wr(idx_ext_lsb, 32'hff, resp_slverr);
    rd_set(~cv);
    rd(8'h70, 32'h0, resp_decerr);
    wr(idx_cfg3, 32'hff, resp_okay);
    rd(idx_cfg3, 32'h07, resp_okay);
    // alert routing with the pin still measuring voltage
    out_of_limit <= 1'b1;
    wr(idx_cfg3, 32'h1, resp_okay);
    repeat (2) @(posedge aclk);
    chk("alert", {31'h0, shared_pin_oe}, 32'h1);
    chk("measure", {31'h0, measure_2v5_enable}, 32'h1);
    chk("pin_out", {31'h0, shared_pin_out}, 32'h0);
    fans_running <= 1'b1;
    thermal_alarm_pin_drive <= 1'b1;
    wr(idx_cfg3, 32'h3, resp_okay);
    repeat (2) @(posedge aclk);
    chk("alert", {31'h0, shared_pin_oe}, 32'h0);
    chk("measure", {31'h0, measure_2v5_enable}, 32'h0);
    chk("full_speed", {31'h0, fans_full_speed}, 32'h0);
    wr(idx_cfg3, 32'h7, resp_okay);
    repeat (2) @(posedge aclk);
    chk("full_speed", {31'h0, fans_full_speed}, 32'h1);
    thermal_alarm_pin_drive <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("full_speed", {31'h0, fans_full_speed}, 32'h0);
    // timer counts five asserted cycles
    wr(idx_timer_ctrl, 32'h1, resp_okay);
    thermal_alarm_pin_drive <= 1'b1;
    repeat (5) @(posedge aclk);
    thermal_alarm_pin_drive <= 1'b0;
    @(posedge aclk);
    rd(idx_thermal_alarm_pin_timer, 32'h5, resp_okay);
    print_verdict;
  end
endmodule
